/* dv/serial_command_decoder_chk.sv */
`timescale 1ns/1ps
module serial_command_decoder_chk (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Watched pins
  input wire cs_n,
  input wire start_pin,
  input wire conv_done,
  input wire clock_source_select,
  input wire dout_oe,
  input wire data_ready_n,
  input wire clk_out_en,
  input wire conv_run,
  input wire trim_start,
  input wire standby,
  input wire readout_cont,
  input wire reset_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  reg [7:0] busy_r;
  // Length of the busy window, read at its end
  always @(posedge clk_sys) begin
    if (sys_rst || !reset_busy) busy_r <= 8'h00;
    else busy_r <= busy_r + 8'h01;
  end
  a_oe_released: assert property (cs_n [*5] |-> !dout_oe)
    else $error("data out driven while deselected");
  a_clk_master: assert property ($stable(clock_source_select) [*4] |-> clk_out_en == clock_source_select)
    else $error("clock output enable wrong");
  a_start_ready: assert property ($rose(start_pin) |-> ##[1:6] data_ready_n)
    else $error("ready not raised by start");
  a_ready_cause: assert property ($fell(data_ready_n) |-> $past(conv_done))
    else $error("ready fell without result");
  a_busy_length: assert property ($fell(reset_busy) |-> busy_r == 8'h24)
    else $error("reset busy length wrong");
  a_reset_values: assert property ($fell(sys_rst) |-> readout_cont && data_ready_n && !standby)
    else $error("wrong state after reset");
  a_trim_pulse: assert property (trim_start |=> !trim_start)
    else $error("trim pulse too long");
  a_standby_idle: assert property (standby [*2] |-> !conv_run)
    else $error("conversions run in standby");
endmodule

bind serial_command_decoder serial_command_decoder_chk u_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .cs_n(cs_n), .start_pin(start_pin), .conv_done(conv_done),
  .clock_source_select(clock_source_select), .dout_oe(dout_oe),
  .data_ready_n(data_ready_n), .clk_out_en(clk_out_en), .conv_run(conv_run),
  .trim_start(trim_start), .standby(standby), .readout_cont(readout_cont),
  .reset_busy(reset_busy));

/* dv/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  // Serial port pins
  output reg cs_n,
  output reg sclk,
  output reg din,
  input wire dout
);
  // Idle bus: select high, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Own select, held low over every byte of a command
  task frame_on;
    #67 cs_n = 1'b0;
    #60;
  endtask
  // Data line left inverted so a stale bit never reads as valid
  task frame_off;
    #60 cs_n = 1'b1;
    din = ~din;
    #300;
  endtask
  // Set on the rise, read just after the fall while the bit still stands
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      sclk = 1'b1;
      din = tx[i];
      #80 sclk = 1'b0;
      #40 rx[i] = dout;
      #40;
    end
    #200;
  endtask
endmodule

/* dv/test_serial_command_decoder.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_serial_command_decoder;
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg start_pin = 1'b0;
  reg conv_done = 1'b0;
  reg clock_source_select = 1'b1;
  reg [15:0] conv_result = 16'h0000;
  reg [15:0] lfsr = 16'h0029;
  reg [95:0] ops = 96'h11081AFF600A100402020C11;
  reg idle_r = 1'b0;
  reg trim_seen = 1'b0;
  reg [7:0] op, a, d0, d1, r0, r1;
  reg [2:0] m;
  wire cs_n, sclk, din, dout, dout_oe, data_ready_n, clk_out_en, conv_run;
  wire filter_restart, trim_start, standby, readout_cont, reset_busy, miso;
  integer n_fail = 0, n_checks = 0, cyc = 0, i;
  // Released line toggles, so a read of a floating bus cannot match
  assign miso = dout_oe ? dout : idle_r;
  serial_command_decoder #(.SETTLE_MODS(4)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ce(1'b1), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .start_pin(start_pin), .data_ready_n(data_ready_n),
    .clock_source_select(clock_source_select), .clk_out_en(clk_out_en),
    .conv_result(conv_result), .conv_done(conv_done), .conv_run(conv_run),
    .filter_restart(filter_restart), .trim_start(trim_start), .standby(standby),
    .readout_cont(readout_cont), .reset_busy(reset_busy));
  spi_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(miso));
  initial forever #10 clk_sys = ~clk_sys;
  // Hang guard, idle pattern and trim pulse capture
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    idle_r <= ~idle_r;
    if (trim_start) trim_seen <= 1'b1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  function [15:0] step(input [15:0] s);
    step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected {standby, continuous, running}; asleep only wake counts
  function [2:0] next_mode(input [7:0] c, input [2:0] p);
    next_mode = p;
    if (!p[2] || c == 8'h02) begin
      case (c)
        8'h02: next_mode[2] = 1'b0;
        8'h04: next_mode = {1'b1, p[1], 1'b0};
        8'h08: next_mode[0] = 1'b1;
        8'h0A: next_mode[0] = 1'b0;
        8'h10: next_mode[1] = 1'b1;
        8'h11: next_mode[1] = 1'b0;
        default: ;
      endcase
    end
  endfunction
  task cmd(input [7:0] c);
    host.frame_on;
    host.xfer(c, r0);
    host.frame_off;
    repeat (12) @(negedge clk_sys);
  endtask
  // Two opcode bytes, then two data bytes
  task regs(input [7:0] c, input [7:0] w0, input [7:0] w1);
    host.frame_on;
    host.xfer(c, r0);
    host.xfer(8'h01, r0);
    host.xfer(w0, r0);
    host.xfer(w1, r1);
    host.frame_off;
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("ready_n", 1'b1, data_ready_n)
    `CHK("clk_en", 1'b1, clk_out_en)
    m = 3'b010;
    for (i = 0; i < 12; i = i + 1) begin
      op = ops[95 - 8 * i -: 8];
      cmd(op);
      m = next_mode(op, m);
      `CHK("mode", m, {standby, readout_cont, conv_run})
    end
    `CHK("trim", 1'b1, trim_seen)
    for (i = 0; i < 3; i = i + 1) begin
      lfsr = step(lfsr);
      a = {3'b000, lfsr[4:1], 1'b0};
      d0 = lfsr[15:8];
      lfsr = step(lfsr);
      d1 = lfsr[7:0];
      regs(8'h40 | a, d0, d1);
      regs(8'h20 | a, 8'h00, 8'h00);
      `CHK("reg0", d0, r0)
      `CHK("reg1", d1, r1)
    end
    cmd(8'h06);
    repeat (50) @(negedge clk_sys);
    cmd(8'h11);
    regs(8'h20 | a, 8'h00, 8'h00);
    `CHK("cleared", 8'h00, r0)
    start_pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK("ready_n", 1'b1, data_ready_n)
    repeat (20) @(negedge clk_sys);
    lfsr = step(lfsr);
    conv_result = lfsr;
    conv_done = 1'b1;
    @(negedge clk_sys) conv_done = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("ready_n", 1'b0, data_ready_n)
    for (i = 0; i < 2; i = i + 1) begin
      host.frame_on;
      host.xfer(8'h12, r0);
      host.xfer(8'h00, r0);
      host.xfer(8'h00, r1);
      host.frame_off;
      `CHK("result", conv_result, {r0, r1})
    end
    @(negedge clk_sys) clock_source_select = 1'b0;
    repeat (5) @(negedge clk_sys);
    `CHK("clk_en", 1'b0, clk_out_en)
    `CHK("oe", 1'b0, dout_oe)
    end_of_test;
  end
endmodule

/* verilog/cmd_decoder_defs.vh */
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH

// Single-byte opcodes
`define OP_WAKE 8'h02
`define OP_SLEEP 8'h04
`define OP_RESET 8'h06
`define OP_START 8'h08
`define OP_STOP 8'h0A
`define OP_TRIM 8'h1A
`define OP_RDC 8'h10
`define OP_SDC 8'h11
`define OP_RDATA 8'h12

// Two-byte opcode prefixes in bits 7:5
`define PFX_FETCH 3'h1
`define PFX_STORE 3'h2
`define PFX_COUNT 3'h0

// Timing, in master clock periods except RESET_MODS, which is in modulator periods
`define MCLK_PER_MOD 4
`define RESET_MODS 9
`define DECODE_MCLK 4
// Settling delay from start to first data ready, in modulator periods
`define SETTLE_MODS 68
// Register file
`define NUM_REGS 32
`define REG_RESET_VAL 8'h00

`endif

/* verilog/serial_command_decoder.v */
`timescale 1ns/1ps
`include "cmd_decoder_defs.vh"

// Functional notes
// [RULE1] Host shares data, clock lines; own selects
// [RULE2] Clock master: source select high, enable set
// [RULE3] Start to data ready delay is fixed
// [RULE4] Host start pulse spans one modulator period
// [RULE5] Settling varies by one modulator period; code realigns the tick on each start, so settling is fixed
// [RULE6] Data out released while select high
// [RULE7] One-byte opcodes; fetch/store take two bytes
// [RULE8] Host holds select low through command
// [RULE9] Decode 7th edge, fetch/store 8th edge; code decodes 10h and 11h on the 8th edge
// [RULE10] System opcodes 02,04,06,08,0A,1A
// [RULE11] Readout opcodes 10,11,12
// [RULE12] Fetch 001 prefix, store 010 prefix
// [RULE13] Second byte 000 plus count minus one
// [RULE14] Continuous readout active after reset
// [RULE15] Fetch ignored during continuous readout
// [RULE16] Single readout repeatable on same result
// [RULE17] Host waits four clocks after wake
// [RULE18] Wake, sleep, reset accepted any time
// [RULE19] Sleep powers down all but reference
// [RULE20] Host sends only wake while asleep
// [RULE21] Reset restarts filter, clears registers
// [RULE22] Reset takes nine modulator periods
// [RULE23] Host spaces bytes four master clocks
// [RULE24] Fetch data MSB on 17th rising edge
// [RULE25] Host sends store data MSB first
// [RULE26] Unknown bytes ignored without effect
module serial_command_decoder #(
  parameter SETTLE_MODS = `SETTLE_MODS
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire sys_rst,
  input wire ce,
  // Serial port pins
  input wire cs_n,
  input wire sclk,
  input wire din,
  output reg dout,
  output reg dout_oe,
  // Conversion pins
  input wire start_pin,
  output reg data_ready_n,
  // Clock sharing
  input wire clock_source_select,
  output reg clk_out_en,
  // Conversion datapath
  input wire [15:0] conv_result,
  input wire conv_done,
  output reg conv_run,
  output reg filter_restart,
  output reg trim_start,
  output reg standby,
  output reg readout_cont,
  output reg reset_busy
);
  localparam [3:0] MOD_DIV = `MCLK_PER_MOD;
  localparam [1:0] ST_OP = 2'h0;
  localparam [1:0] ST_CNT = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  localparam [7:0] SETTLE_W = SETTLE_MODS;
  localparam [3:0] RST_MODS = `RESET_MODS;

  wire cs_n_s;
  wire sclk_s;
  wire din_s;
  wire start_s;
  wire mod_tick;
  reg sclk_d_r;
  reg start_d_r;
  reg [7:0] shift_r;
  reg [3:0] bit_r;
  reg [1:0] state_r;
  reg is_store_r;
  reg [4:0] addr_r;
  reg [4:0] left_r;
  reg [7:0] regs_r [0:`NUM_REGS-1];
  reg [15:0] out_r;
  reg [15:0] held_r;
  reg [4:0] out_cnt_r;
  reg [7:0] settle_r;
  reg [3:0] rst_cnt_r;
  reg restart_nxt;
  reg rd_pend_r;
  reg tx_r;
  integer i;

  // Serial and start pins cross into clk_sys first
  sync2 #(.RESET_VAL(1'b1)) u_cs (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .d(cs_n), .q(cs_n_s));
  sync2 #(.RESET_VAL(1'b0)) u_sclk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .d(sclk), .q(sclk_s));
  sync2 #(.RESET_VAL(1'b0)) u_din (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .d(din), .q(din_s));
  sync2 #(.RESET_VAL(1'b0)) u_start (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .d(start_pin), .q(start_s));

  // Modulator tick, realigned on each start edge
  tick_div #(.DIV(`MCLK_PER_MOD)) u_mod (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .restart(restart_nxt), .tick(mod_tick));

  wire sclk_fall = sclk_d_r & ~sclk_s & ~cs_n_s;
  wire sclk_rise = ~sclk_d_r & sclk_s & ~cs_n_s;
  wire [7:0] byte_now = {shift_r[6:0], din_s};
  // Seven bits in hand: the 7th falling edge completes the opcode view
  wire [7:0] op7 = {shift_r[5:0], din_s, 1'b0};
  wire edge7 = sclk_fall && bit_r == 4'd6 && state_r == ST_OP;
  wire edge8 = sclk_fall && bit_r == 4'd7;
  wire op_wake = edge7 && op7 == `OP_WAKE;
  wire op_sleep = edge7 && op7 == `OP_SLEEP;
  wire op_rst = edge7 && op7 == `OP_RESET;
  wire sys_ok = edge7 && !standby && !reset_busy;
  wire op_start = sys_ok && op7 == `OP_START;
  wire op_stop = sys_ok && op7 == `OP_STOP;
  wire op_trim = sys_ok && op7 == `OP_TRIM;
  // 10h and 11h differ only in bit 0, so they wait for the 8th edge
  wire sys_ok8 = edge8 && state_r == ST_OP && !standby && !reset_busy;
  wire op_rdc = sys_ok8 && byte_now == `OP_RDC;
  wire op_sdc = sys_ok8 && byte_now == `OP_SDC;
  wire op_rd = sys_ok && op7 == `OP_RDATA;
  wire start_rise = start_s & ~start_d_r;

  // Start request from pin edge or opcode
  always @* begin
    restart_nxt = start_rise | op_start | op_rst; // [RULE3]
  end

  // Serial shifter, opcode decode and register access
  always @(posedge clk_sys) begin
    if (sys_rst || (ce && op_rst)) begin
      sclk_d_r <= 1'b0;
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      state_r <= ST_OP;
      is_store_r <= 1'b0;
      addr_r <= 5'h00;
      left_r <= 5'h00;
      out_r <= 16'h0000;
      out_cnt_r <= 5'h00;
      readout_cont <= 1'b1; // [RULE14]
      rd_pend_r <= 1'b0;
      tx_r <= 1'b0;
      standby <= 1'b0;
      trim_start <= 1'b0;
      for (i = 0; i < `NUM_REGS; i = i + 1) begin
        regs_r[i] <= `REG_RESET_VAL; // [RULE21]
      end
    end else if (ce) begin
      sclk_d_r <= sclk_s;
      trim_start <= op_trim; // [RULE10]
      if (cs_n_s) begin
        // Deselect abandons any partial command
        bit_r <= 4'h0;
        state_r <= ST_OP;
        out_cnt_r <= 5'h00;
        rd_pend_r <= 1'b0;
        tx_r <= 1'b0;
      end else if (sclk_fall) begin
        shift_r <= byte_now;
        bit_r <= (bit_r == 4'd7) ? 4'h0 : bit_r + 4'h1;
      end
      // Single-byte commands act on the 7th edge, except 10h and 11h on the 8th
      if (op_wake) begin
        standby <= 1'b0; // [RULE18]
      end
      if (op_sleep) begin
        standby <= 1'b1; // [RULE19]
      end
      if (op_rdc) begin
        readout_cont <= 1'b1; // [RULE11]
      end
      if (op_sdc) begin
        readout_cont <= 1'b0;
      end
      // Result loads on the 8th edge so the 8th rise cannot shift its MSB away
      if (op_rd) begin
        rd_pend_r <= 1'b1;
      end
      if (edge8 && rd_pend_r) begin
        rd_pend_r <= 1'b0;
        out_r <= held_r; // [RULE16]
        out_cnt_r <= 5'h10;
      end
      // Two-byte commands decode on the 8th edge
      if (edge8 && !cs_n_s && !standby && !reset_busy) begin
        case (state_r)
          ST_OP: begin
            if (byte_now[7:5] == `PFX_STORE) begin // [RULE12]
              is_store_r <= 1'b1;
              addr_r <= byte_now[4:0];
              state_r <= ST_CNT; // [RULE7]
            end else if (byte_now[7:5] == `PFX_FETCH && !readout_cont) begin // [RULE15]
              is_store_r <= 1'b0;
              addr_r <= byte_now[4:0];
              state_r <= ST_CNT; // [RULE9]
            end
          end
          ST_CNT: begin
            if (byte_now[7:5] == `PFX_COUNT) begin // [RULE13]
              left_r <= byte_now[4:0];
              state_r <= ST_DATA;
              if (!is_store_r) begin
                out_r <= {regs_r[addr_r], 8'h00}; // [RULE24]
                out_cnt_r <= 5'h08;
              end
            end else begin
              state_r <= ST_OP; // [RULE26]
            end
          end
          ST_DATA: begin
            if (is_store_r) begin
              regs_r[addr_r] <= byte_now; // [RULE25]
            end
            if (left_r == 5'h00) begin
              state_r <= ST_OP;
            end else begin
              left_r <= left_r - 5'h01;
              addr_r <= addr_r + 5'h01;
              if (!is_store_r) begin
                out_r <= {regs_r[addr_r + 5'h01], 8'h00};
                out_cnt_r <= 5'h08;
              end
            end
          end
          default: state_r <= ST_OP;
        endcase
      end
      // Shift out on rising edges while data remains
      if (sclk_rise && out_cnt_r != 5'h00 && !(edge8 && state_r != ST_OP)) begin
        // Present the MSB on this rise, then move the next bit up
        tx_r <= out_r[15]; // [RULE24]
        out_r <= {out_r[14:0], 1'b0};
        out_cnt_r <= out_cnt_r - 5'h01;
      end
    end
  end

  // Data out follows the shifter; released while deselected
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else if (ce) begin
      dout <= tx_r;
      dout_oe <= ~cs_n_s; // [RULE6]
    end
  end

  // Clock master drives its clock out when strapped
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_out_en <= 1'b0;
    end else if (ce) begin
      clk_out_en <= clock_source_select; // [RULE2]
    end
  end

  // Reset busy window counted in modulator periods
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_cnt_r <= 4'h0;
      reset_busy <= 1'b0;
      filter_restart <= 1'b0;
    end else if (ce) begin
      filter_restart <= op_rst | restart_nxt; // [RULE21]
      if (op_rst) begin
        rst_cnt_r <= RST_MODS; // [RULE22]
        reset_busy <= 1'b1;
      end else if (mod_tick && rst_cnt_r != 4'h0) begin
        rst_cnt_r <= rst_cnt_r - 4'h1;
        reset_busy <= (rst_cnt_r != 4'h1);
      end
    end
  end

  // Conversion control: fixed settle, then data ready per result
  always @(posedge clk_sys) begin
    if (sys_rst || (ce && op_rst)) begin
      start_d_r <= 1'b0;
      conv_run <= 1'b0;
      settle_r <= 8'h00;
      data_ready_n <= 1'b1;
      held_r <= 16'h0000;
    end else if (ce) begin
      start_d_r <= start_s;
      if (restart_nxt && !standby) begin
        conv_run <= 1'b1;
        settle_r <= SETTLE_W; // [RULE3]
        data_ready_n <= 1'b1;
      end else if (op_stop || op_sleep || (start_d_r && !start_s)) begin // [RULE19]
        conv_run <= 1'b0;
      end else if (settle_r != 8'h00) begin
        if (mod_tick) begin
          settle_r <= settle_r - 8'h01; // [RULE5]
        end
      end else if (conv_run && conv_done) begin
        held_r <= conv_result;
        data_ready_n <= 1'b0;
      end else if (sclk_fall) begin
        data_ready_n <= 1'b1;
      end
    end
  end
endmodule

/* verilog/sync2.v */
`timescale 1ns/1ps
module sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  input wire ce,
  // Async level
  input wire d,
  output reg q
);
  reg meta_r;

  // Two stages; only the second is read outside
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* verilog/tick_div.v */
`timescale 1ns/1ps
module tick_div #(
  parameter DIV = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  input wire ce,
  input wire restart,
  // One-cycle tick every DIV cycles
  output reg tick
);
  reg [7:0] cnt_r;

  // Restart keeps ticks aligned to the start edge
  // The restart cycle counts as the first, so ticks land every DIV cycles after it
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (ce && restart) begin
      cnt_r <= 8'h01;
      tick <= 1'b0;
    end else if (ce) begin
      if (cnt_r == DIV[7:0] - 8'h01) begin
        cnt_r <= 8'h00;
        tick <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 8'h01;
        tick <= 1'b0;
      end
    end
  end
endmodule
